// file: rtl/core_mem_pkg.sv
// Package: core memory map offsets, field positions, reset values and carriers
package core_mem_pkg;

	localparam int STACK_DEPTH = 16;
	localparam int STACK_WIDTH = 15;
	localparam int PC_WIDTH    = 15;
	localparam int IMPL_AW     = 14;
	localparam int DADDR_WIDTH = 12;
	localparam int BANK_COUNT  = 32;

	localparam logic [14:0] RESET_VECTOR = 15'h0000;
	localparam logic [14:0] IRQ_VECTOR   = 15'h0004;
	localparam logic [14:0] LAST_PROG    = 15'h3FFF;

	localparam logic [6:0] OFS_IND0      = 7'h00;
	localparam logic [6:0] OFS_IND1      = 7'h01;
	localparam logic [6:0] OFS_PCL       = 7'h02;
	localparam logic [6:0] OFS_STATUS    = 7'h03;
	localparam logic [6:0] OFS_PTR0_LO   = 7'h04;
	localparam logic [6:0] OFS_PTR0_HI   = 7'h05;
	localparam logic [6:0] OFS_PTR1_LO   = 7'h06;
	localparam logic [6:0] OFS_PTR1_HI   = 7'h07;
	localparam logic [6:0] OFS_BANK_SEL  = 7'h08;
	localparam logic [6:0] OFS_WACC      = 7'h09;
	localparam logic [6:0] OFS_PCLATCH   = 7'h0A;
	localparam logic [6:0] OFS_IRQ_CTL   = 7'h0B;
	localparam logic [6:0] OFS_PERIPH_LO = 7'h0C;
	localparam logic [6:0] OFS_PERIPH_HI = 7'h1F;
	localparam logic [6:0] OFS_GPR_LO    = 7'h20;
	localparam logic [6:0] OFS_GPR_HI    = 7'h6F;
	localparam logic [6:0] OFS_COMMON_LO = 7'h70;
	localparam logic [4:0] BANK_NOPERI_LO = 5'h1B;
	localparam logic [4:0] BANK_NOPERI_HI = 5'h1D;

	localparam int ST_WDT_EXP = 4;
	localparam int ST_SLEEP   = 3;
	localparam int ST_ZERO    = 2;
	localparam int ST_NIBBLE  = 1;
	localparam int ST_CARRY   = 0;
	localparam int PTR_PROG_BIT = 7;

	localparam logic [7:0] STATUS_RESET  = 8'h18;
	localparam logic [7:0] IRQCTL_RESET  = 8'h01;
	localparam logic [7:0] BYTE_RESET    = 8'h00;

	typedef enum logic [1:0] {ALU_NONE, ALU_ARITH, ALU_ROR, ALU_ROL} alu_op_type;

	// One data-memory access from the execution core
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        indirect;
		logic [6:0]  ofs;
		logic [7:0]  wdata;
	} dmem_req_type;

	// Request to the arithmetic unit that updates the status flags
	typedef struct packed {
		alu_op_type  op;
		logic        sets_zdc;
		logic [7:0]  a;
		logic [7:0]  b;
		logic        cin;
		logic        clear;
	} alu_req_type;

endpackage

// file: rtl/core_memory_organization.sv
// Core memory organization: stack, pointers, program space and data-memory map
`timescale 1ns/1ps

module core_memory_organization
	import core_mem_pkg::*;
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	input  wire logic              i_por,
	input  wire logic              i_stack_reset_en,
	input  wire logic              i_push,
	input  wire logic              i_pop,
	input  wire logic              i_irq_entry,
	input  wire logic              i_pc_load,
	input  wire logic [14:0]       i_pc_value,
	input  wire logic              i_pc_step,
	input  wire dmem_req_type      i_dmem,
	input  wire alu_req_type       i_alu,
	input  wire logic              i_wdt_refresh,
	input  wire logic              i_sleep,
	input  wire logic              i_wdt_timeout,
	input  wire logic [13:0]       i_prog_word,
	input  wire logic [7:0]        i_periph_rdata,
	input  wire logic [7:0]        i_eeprom_rdata,
	output logic [14:0]            o_pc,
	output logic [13:0]            o_prog_addr,
	output logic [14:0]            o_stack_top,
	output logic                   o_stack_overflow_flag,
	output logic                   o_stack_underflow_flag,
	output logic                   o_soft_reset,
	output logic [11:0]            o_daddr,
	output logic                   o_periph_sel,
	output logic                   o_eeprom_sel,
	output logic [7:0]             o_rdata,
	output logic                   o_extra_cycle,
	output logic [7:0]             o_status_flags
);

	////////////////////////////////////////////////////////////////////////////
	// Return stack
	logic [STACK_WIDTH-1:0] stack_mem [STACK_DEPTH];
	logic [3:0]             stack_ptr;
	logic                   stack_full;
	logic                   stack_empty;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			stack_ptr   <= 4'h0;
			stack_full  <= 1'b0;
			stack_empty <= 1'b1;
		end
		else if (i_push && !stack_full)
		begin
			stack_mem[stack_ptr] <= o_pc;
			stack_ptr            <= stack_ptr + 4'h1;
			stack_empty          <= 1'b0;
			stack_full           <= (stack_ptr == 4'hF);
		end
		else if (i_pop && !stack_empty)
		begin
			stack_ptr   <= stack_ptr - 4'h1;
			stack_full  <= 1'b0;
			stack_empty <= (stack_ptr == 4'h1);
		end
	end

	assign o_stack_top = stack_mem[stack_ptr - 4'h1];

	// Flags are sticky until a power-on reset, so software can see why it restarted
	always_ff @(posedge i_ref_clk)
	begin
		if (i_por)
		begin
			o_stack_overflow_flag  <= 1'b0;
			o_stack_underflow_flag <= 1'b0;
		end
		else
		begin
			if (i_push && stack_full)
				o_stack_overflow_flag <= 1'b1;
			if (i_pop && stack_empty)
				o_stack_underflow_flag <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			o_soft_reset <= 1'b0;
		else
			o_soft_reset <= i_stack_reset_en &&
				((i_push && stack_full) || (i_pop && stack_empty));
	end

	////////////////////////////////////////////////////////////////////////////
	// Program counter
	logic [7:0] pc_upper_latch;
	logic       pcl_write;

	assign pcl_write = i_dmem.wr && !i_dmem.indirect && i_dmem.ofs == OFS_PCL;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			o_pc <= RESET_VECTOR;
		else if (i_irq_entry)
			o_pc <= IRQ_VECTOR;
		else if (i_pc_load)
			o_pc <= i_pc_value;
		else if (pcl_write)
			o_pc <= {pc_upper_latch[6:0], i_dmem.wdata};
		else if (i_pc_step && !o_extra_cycle)
			o_pc <= o_pc + 15'h0001;
	end

	// Upper address bit dropped: words above the top alias into the array
	// A pointer read of program space borrows the fetch port for its own word
	assign o_prog_addr = (ind_access && ind_prog) ? ind_ptr[IMPL_AW-1:0]
		: o_pc[IMPL_AW-1:0];

	////////////////////////////////////////////////////////////////////////////
	// Core registers
	logic [7:0] ptr_lo [2];
	logic [7:0] ptr_hi [2];
	logic [7:0] bank_select;
	logic [7:0] working_accum;
	logic [7:0] irq_control_reg;
	logic       ind_sel;
	logic [15:0] ind_ptr;
	logic       ind_prog;
	logic       ind_access;

	assign ind_sel    = (i_dmem.ofs == OFS_IND1);
	assign ind_access = (i_dmem.rd || i_dmem.wr) &&
		(i_dmem.ofs == OFS_IND0 || i_dmem.ofs == OFS_IND1);
	assign ind_ptr    = {ptr_hi[ind_sel], ptr_lo[ind_sel]};
	assign ind_prog   = ind_ptr[8+PTR_PROG_BIT];

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++)
		begin : g_ptr
			always_ff @(posedge i_ref_clk)
			begin
				if (i_rst)
				begin
					ptr_lo[gp] <= BYTE_RESET;
					ptr_hi[gp] <= BYTE_RESET;
				end
				else if (i_dmem.wr && !i_dmem.indirect)
				begin
					if (i_dmem.ofs == OFS_PTR0_LO + 7'(2*gp))
						ptr_lo[gp] <= i_dmem.wdata;
					if (i_dmem.ofs == OFS_PTR0_HI + 7'(2*gp))
						ptr_hi[gp] <= i_dmem.wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			bank_select     <= BYTE_RESET;
			working_accum   <= BYTE_RESET;
			pc_upper_latch  <= BYTE_RESET;
			irq_control_reg <= IRQCTL_RESET;
		end
		else if (i_dmem.rd && ind_access && ind_prog && o_extra_cycle)
			working_accum <= i_prog_word[7:0];
		else if (i_dmem.wr && !i_dmem.indirect)
		begin
			case (i_dmem.ofs)
				OFS_BANK_SEL: bank_select     <= {3'h0, i_dmem.wdata[4:0]};
				OFS_WACC:     working_accum   <= i_dmem.wdata;
				OFS_PCLATCH:  pc_upper_latch  <= {1'b0, i_dmem.wdata[6:0]};
				OFS_IRQ_CTL:  irq_control_reg <= {i_dmem.wdata[7:6], 5'h00, i_dmem.wdata[0]};
				default:      ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Extra cycle for program-memory fetch through a pointer
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			o_extra_cycle <= 1'b0;
		else
			o_extra_cycle <= ind_access && i_dmem.rd && ind_prog && !o_extra_cycle;
	end

	////////////////////////////////////////////////////////////////////////////
	// Address generation and region decode
	logic [6:0] loc;

	always_comb
	begin
		// Direct: bank from bank select; indirect: linear pointer bits
		if (i_dmem.indirect || ind_access)
			o_daddr = ind_ptr[DADDR_WIDTH-1:0];
		else
			o_daddr = {bank_select[4:0], i_dmem.ofs};
	end

	assign loc = o_daddr[6:0];
	assign o_periph_sel = (loc >= OFS_PERIPH_LO) && (loc <= OFS_PERIPH_HI) &&
		!(o_daddr[11:7] >= BANK_NOPERI_LO && o_daddr[11:7] <= BANK_NOPERI_HI) &&
		!(ind_access && ind_ptr[15]);
	// Pointer space below program space with bit 12 set reaches the EEPROM; bits 12 and 15 are the only bits decoded above data memory
	assign o_eeprom_sel = ind_access && !ind_prog && ind_ptr[12];

	////////////////////////////////////////////////////////////////////////////
	// General and common RAM
	logic [7:0] gen_ram [BANK_COUNT*80];
	logic [7:0] com_ram [16];
	logic [11:0] gen_idx;
	logic        is_gen;
	logic        is_com;
	logic        ram_wr;

	// Bank number widened before the product so bank 31 does not overflow
	assign gen_idx = 12'(o_daddr[11:7]) * 12'd80 + 12'(loc - OFS_GPR_LO);
	assign is_gen  = (loc >= OFS_GPR_LO) && (loc <= OFS_GPR_HI);
	assign is_com  = (loc >= OFS_COMMON_LO);
	// Program space and EEPROM are never written here
	assign ram_wr  = i_dmem.wr && !(ind_access && (ind_prog || o_eeprom_sel));

	always_ff @(posedge i_ref_clk)
	begin
		if (ram_wr && is_gen && !(ind_access && ind_ptr[15]))
			gen_ram[gen_idx] <= i_dmem.wdata;
		if (ram_wr && is_com && !(ind_access && ind_ptr[15]))
			com_ram[loc[3:0]] <= i_dmem.wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Status register
	logic [1:0] status_rst_q;
	logic [2:0] status_alu_q;
	logic [8:0] sum;
	logic [4:0] nib;
	logic       status_dest;

	assign sum = {1'b0, i_alu.a} + {1'b0, i_alu.b} + {8'h00, i_alu.cin};
	assign nib = {1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]} + {4'h0, i_alu.cin};
	assign status_dest = i_dmem.wr && !i_dmem.indirect && i_dmem.ofs == OFS_STATUS;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			status_rst_q <= STATUS_RESET[ST_WDT_EXP:ST_SLEEP];
		else
		begin
			if (i_wdt_timeout)
				status_rst_q[1] <= 1'b0;
			else if (i_wdt_refresh || i_sleep)
				status_rst_q[1] <= 1'b1;
			if (i_sleep)
				status_rst_q[0] <= 1'b0;
			else if (i_wdt_refresh)
				status_rst_q[0] <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			status_alu_q <= STATUS_RESET[ST_ZERO:ST_CARRY];
		else if (i_alu.clear && status_dest)
			status_alu_q[ST_ZERO] <= 1'b1;
		else if (i_alu.op == ALU_ARITH)
		begin
			status_alu_q[ST_ZERO]   <= (sum[7:0] == 8'h00);
			status_alu_q[ST_NIBBLE] <= nib[4];
			status_alu_q[ST_CARRY]  <= sum[8];
		end
		else if (i_alu.op == ALU_ROR)
			status_alu_q[ST_CARRY] <= i_alu.a[0];
		else if (i_alu.op == ALU_ROL)
			status_alu_q[ST_CARRY] <= i_alu.a[7];
		else if (i_alu.sets_zdc)
			status_alu_q[ST_ZERO] <= (i_alu.a == 8'h00);
		else if (status_dest)
			status_alu_q <= i_dmem.wdata[ST_ZERO:ST_CARRY];
	end

	assign o_status_flags = {3'h0, status_rst_q, status_alu_q};

	////////////////////////////////////////////////////////////////////////////
	// Read data mux
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			o_rdata <= BYTE_RESET;
		else if (ind_access && ind_prog)
			o_rdata <= i_prog_word[7:0];
		else if (o_eeprom_sel)
			o_rdata <= i_eeprom_rdata;
		else if (loc <= OFS_IRQ_CTL && !ind_access)
		begin
			case (loc)
				OFS_PCL:      o_rdata <= o_pc[7:0];
				OFS_STATUS:   o_rdata <= o_status_flags;
				OFS_PTR0_LO:  o_rdata <= ptr_lo[0];
				OFS_PTR0_HI:  o_rdata <= ptr_hi[0];
				OFS_PTR1_LO:  o_rdata <= ptr_lo[1];
				OFS_PTR1_HI:  o_rdata <= ptr_hi[1];
				OFS_BANK_SEL: o_rdata <= bank_select;
				OFS_WACC:     o_rdata <= working_accum;
				OFS_PCLATCH:  o_rdata <= pc_upper_latch;
				OFS_IRQ_CTL:  o_rdata <= irq_control_reg;
				default:      o_rdata <= BYTE_RESET;
			endcase
		end
		else if (o_periph_sel)
			o_rdata <= i_periph_rdata;
		else if (is_gen)
			o_rdata <= gen_ram[gen_idx];
		else if (is_com)
			o_rdata <= com_ram[loc[3:0]];
		else
			o_rdata <= BYTE_RESET;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_reset_vector: assert property (@(posedge i_ref_clk)
		$past(i_rst) |-> o_pc == RESET_VECTOR)
		else $error("pc not at reset vector");
	a_irq_vector: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_irq_entry |=> o_pc == IRQ_VECTOR)
		else $error("irq vector missed");
	a_overflow_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst || i_por)
		(i_push && stack_full) |=> o_stack_overflow_flag)
		else $error("overflow flag not set");
	a_underflow_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst || i_por)
		(i_pop && stack_empty) |=> o_stack_underflow_flag && o_soft_reset == $past(i_stack_reset_en))
		else $error("underflow handling wrong");
	a_extra_cycle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(ind_access && i_dmem.rd && ind_prog && !o_extra_cycle) |=> o_extra_cycle ##1 !o_extra_cycle || ind_access)
		else $error("extra cycle missing");
	a_status_upper: assert property (@(posedge i_ref_clk)
		o_status_flags[7:5] == 3'h0)
		else $error("status upper bits nonzero");
	a_sleep_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_sleep |=> !o_status_flags[ST_SLEEP] && o_status_flags[ST_WDT_EXP] == !$past(i_wdt_timeout))
		else $error("sleep flags wrong");
	a_carry_arith: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_alu.op == ALU_ARITH && !(i_alu.clear && status_dest)) |=> o_status_flags[ST_CARRY] == $past(sum[8]))
		else $error("carry wrong");
	a_prog_wrap: assert property (@(posedge i_ref_clk)
		!(ind_access && ind_prog) |-> o_prog_addr == (o_pc[13:0] & LAST_PROG[13:0]))
		else $error("program address wrap wrong");

endmodule // core_memory_organization

// file: test/cpu_side_model.sv
// Far-side model: program words, peripheral and EEPROM read data
`timescale 1ns/1ps

module cpu_side_model
(
	input  wire logic        i_ref_clk,
	input  wire logic [13:0] i_prog_addr,
	input  wire logic [11:0] i_daddr,
	input  wire logic        i_periph_sel,
	input  wire logic        i_eeprom_sel,
	output logic      [13:0] o_prog_word,
	output logic      [7:0]  o_periph_rdata,
	output logic      [7:0]  o_eeprom_rdata
);
	logic [7:0] periph_idle = 8'hA5;
	logic [7:0] eeprom_idle = 8'h5A;

	////////////////////////////////////////////////////////////////////////////////
	// Low byte scrambled from the low address byte, so a word from a place under 256 words away never matches
	assign o_prog_word = {6'h15, i_prog_addr[7:0] ^ 8'h5A};

	// Deselected lines toggle each cycle instead of holding a stale byte
	always_ff @(posedge i_ref_clk)
	begin
		periph_idle <= ~periph_idle;
		eeprom_idle <= ~eeprom_idle;
	end

	assign o_periph_rdata = i_periph_sel ? (i_daddr[7:0] ^ 8'hC3) : periph_idle;
	assign o_eeprom_rdata = i_eeprom_sel ? 8'h96 : eeprom_idle;
endmodule // cpu_side_model

// file: test/tb_core_memory_organization.sv
// Testbench: core memory map, stack, program counter and status flags
`timescale 1ns/1ps

module tb_core_memory_organization
	import core_mem_pkg::*;
;
	logic         ref_clk;
	logic         rst, por, sre;
	logic [4:0]   ctl;
	logic [2:0]   ev;
	logic [14:0]  pcv;
	dmem_req_type dmem;
	alu_req_type  alu;
	logic [13:0]  prog_word, prog_addr;
	logic [7:0]   periph_rd, eeprom_rd, rdata, status;
	logic [14:0]  pc, stack_top;
	logic         ovf, unf, soft_rst, periph_sel, eeprom_sel, extra, soft_seen;
	logic [11:0]  daddr, addr_seen;
	logic [1:0]   sel_seen;
	int           fails, comparisons;

	// Each row: offset, byte written, byte read back
	localparam logic [22:0] ROWS [0:10] = '{
		{OFS_PTR0_LO, 8'hA5, 8'hA5}, {OFS_PTR0_HI, 8'h3C, 8'h3C},
		{OFS_PTR1_LO, 8'h5A, 8'h5A}, {OFS_PTR1_HI, 8'h01, 8'h01},
		{OFS_WACC, 8'hC3, 8'hC3}, {OFS_PCLATCH, 8'h12, 8'h12},
		{OFS_STATUS, 8'hFF, 8'h1F}, {OFS_STATUS, 8'h00, 8'h18},
		{OFS_GPR_LO, 8'h77, 8'h77}, {OFS_GPR_HI, 8'h99, 8'h99},
		{OFS_COMMON_LO, 8'hE1, 8'hE1}};

	core_memory_organization dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_por(por),
		.i_stack_reset_en(sre), .i_push(ctl[4]), .i_pop(ctl[3]), .i_irq_entry(ctl[2]),
		.i_pc_load(ctl[1]), .i_pc_value(pcv), .i_pc_step(ctl[0]), .i_dmem(dmem),
		.i_alu(alu), .i_wdt_refresh(ev[2]), .i_sleep(ev[1]), .i_wdt_timeout(ev[0]),
		.i_prog_word(prog_word), .i_periph_rdata(periph_rd), .i_eeprom_rdata(eeprom_rd),
		.o_pc(pc), .o_prog_addr(prog_addr), .o_stack_top(stack_top),
		.o_stack_overflow_flag(ovf), .o_stack_underflow_flag(unf), .o_soft_reset(soft_rst),
		.o_daddr(daddr), .o_periph_sel(periph_sel), .o_eeprom_sel(eeprom_sel),
		.o_rdata(rdata), .o_extra_cycle(extra), .o_status_flags(status));

	cpu_side_model u_far (.i_ref_clk(ref_clk), .i_prog_addr(prog_addr), .i_daddr(daddr),
		.i_periph_sel(periph_sel), .i_eeprom_sel(eeprom_sel), .o_prog_word(prog_word),
		.o_periph_rdata(periph_rd), .o_eeprom_rdata(eeprom_rd));

	////////////////////////////////////////////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task final_report;
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Selects are combinational, so they are caught while the request is up
	task req(input logic r, input logic w, input logic ind, input logic [6:0] o,
		input logic [7:0] d);
		@(posedge ref_clk);
		dmem <= {r, w, ind, o, d};
		#1;
		sel_seen = {periph_sel, eeprom_sel};
		addr_seen = daddr;
		@(posedge ref_clk);
		dmem <= '0;
		#1;
	endtask

	task pulse_ctl(input logic [4:0] v);
		@(posedge ref_clk);
		ctl <= v;
		@(posedge ref_clk);
		ctl <= '0;
		#1;
	endtask

	task pulse_ev(input logic [2:0] v);
		@(posedge ref_clk);
		ev <= v;
		@(posedge ref_clk);
		ev <= '0;
		#1;
	endtask

	task alu_do(input logic [20:0] a_req, input logic wst);
		@(posedge ref_clk);
		alu <= a_req;
		if (wst)
			dmem <= {3'b010, OFS_STATUS, 8'h00};
		@(posedge ref_clk);
		alu <= '0;
		dmem <= '0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Whole run is a few hundred cycles; this leaves ample margin
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		fails++;
		final_report();
	end

	initial
	begin
		rst = 1'b1; por = 1'b1; sre = 1'b0; ctl = '0; ev = '0; pcv = '0;
		dmem = '0; alu = '0; fails = 0; comparisons = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		por <= 1'b0;
		@(posedge ref_clk);
		#1;
		check(pc, 16'h0000);
		check(status, 16'h0018);
		check({ovf, unf}, 16'h0000);
		for (int i = 0; i < 11; i++)
		begin
			req(1'b0, 1'b1, 1'b0, ROWS[i][22:16], ROWS[i][15:8]);
			req(1'b1, 1'b0, 1'b0, ROWS[i][22:16], 8'h00);
			check(rdata, ROWS[i][7:0]);
		end
		// Peripheral window, then the first bank that has none
		req(1'b1, 1'b0, 1'b0, OFS_PERIPH_LO, 8'h00);
		check({sel_seen, rdata}, 16'h02CF);
		req(1'b0, 1'b1, 1'b0, OFS_BANK_SEL, 8'h1B);
		req(1'b1, 1'b0, 1'b0, OFS_PERIPH_LO, 8'h00);
		check({sel_seen, rdata}, 16'h0000);
		check(addr_seen, 16'h0D8C);
		req(1'b0, 1'b1, 1'b0, OFS_BANK_SEL, 8'h02);
		req(1'b1, 1'b0, 1'b0, OFS_COMMON_LO, 8'h00);
		check(rdata, 16'h00E1);
		req(1'b1, 1'b0, 1'b0, OFS_PTR0_LO, 8'h00);
		check(rdata, 16'h00A5);
		req(1'b0, 1'b1, 1'b0, OFS_BANK_SEL, 8'h00);
		// Pointer into data memory, then EEPROM
		req(1'b0, 1'b1, 1'b0, OFS_PTR1_HI, 8'h00);
		req(1'b0, 1'b1, 1'b0, OFS_PTR1_LO, 8'h20);
		req(1'b1, 1'b0, 1'b1, OFS_IND1, 8'h00);
		check({addr_seen[7:0], rdata}, 16'h2077);
		req(1'b0, 1'b1, 1'b1, OFS_IND1, 8'h3E);
		req(1'b1, 1'b0, 1'b0, OFS_GPR_LO, 8'h00);
		check(rdata, 16'h003E);
		req(1'b0, 1'b1, 1'b0, OFS_PTR1_HI, 8'h10);
		req(1'b1, 1'b0, 1'b1, OFS_IND1, 8'h00);
		check({sel_seen, rdata}, 16'h0196);
		// Program word through pointer 0: read held over the extra cycle
		req(1'b0, 1'b1, 1'b0, OFS_PTR0_HI, 8'h80);
		req(1'b0, 1'b1, 1'b0, OFS_PTR0_LO, 8'h12);
		@(posedge ref_clk);
		dmem <= {3'b101, OFS_IND0, 8'h00};
		@(posedge ref_clk);
		#1;
		check({extra, rdata}, 16'h0148);
		@(posedge ref_clk);
		dmem <= '0;
		#1;
		check(extra, 16'h0000);
		req(1'b1, 1'b0, 1'b0, OFS_WACC, 8'h00);
		check(rdata, 16'h0048);
		// Status flag logic
		alu_do({ALU_ARITH, 1'b0, 8'h0F, 8'h01, 2'b00}, 1'b0);
		check(status, 16'h001A);
		alu_do({ALU_ARITH, 1'b0, 8'h05, 8'hFD, 2'b00}, 1'b0);
		check(status, 16'h001B);
		alu_do({ALU_ARITH, 1'b0, 8'h01, 8'h01, 2'b00}, 1'b0);
		check(status, 16'h0018);
		alu_do({ALU_NONE, 1'b0, 8'h00, 8'h00, 2'b01}, 1'b1);
		check(status, 16'h001C);
		alu_do({ALU_ARITH, 1'b0, 8'hFF, 8'h01, 2'b00}, 1'b1);
		check(status, 16'h001F);
		alu_do({ALU_NONE, 1'b1, 8'h05, 8'h00, 2'b00}, 1'b0);
		check(status, 16'h001B);
		alu_do({ALU_ROR, 1'b0, 8'h01, 8'h00, 2'b00}, 1'b0);
		check(status[0], 16'h0001);
		alu_do({ALU_ROL, 1'b0, 8'h7F, 8'h00, 2'b00}, 1'b0);
		check(status[0], 16'h0000);
		alu_do({ALU_ROL, 1'b0, 8'h80, 8'h00, 2'b00}, 1'b0);
		check(status[0], 16'h0001);
		pulse_ev(3'b010);
		check(status[4:3], 16'h0002);
		pulse_ev(3'b001);
		check(status[4:3], 16'h0000);
		pulse_ev(3'b100);
		check(status[4:3], 16'h0003);
		// Program counter width, wrap and interrupt vector
		pulse_ctl(5'b00001);
		pcv <= 15'h4005;
		pulse_ctl(5'b00010);
		check({pc, 1'b0}, {15'h4005, 1'b0});
		check(prog_addr, 16'h0005);
		pcv <= 15'h7FFF;
		pulse_ctl(5'b00010);
		pulse_ctl(5'b00001);
		check(pc, 16'h0000);
		pulse_ctl(5'b00100);
		check(pc, 16'h0004);
		// Stack: fill, overflow, drain, underflow with soft reset enabled
		for (int k = 0; k < 16; k++)
		begin
			pcv <= 15'(100 + k);
			pulse_ctl(5'b00010);
			pulse_ctl(5'b10000);
		end
		check({ovf, stack_top}, 16'h0073);
		pulse_ctl(5'b10000);
		check({ovf, stack_top}, 16'h8073);
		for (int j = 0; j < 16; j++)
		begin
			check(stack_top, 16'(115 - j));
			pulse_ctl(5'b01000);
		end
		sre <= 1'b1;
		pulse_ctl(5'b01000);
		soft_seen = soft_rst;
		@(posedge ref_clk);
		#1;
		soft_seen = soft_seen | soft_rst;
		check({unf, soft_seen}, 16'h0003);
		@(posedge ref_clk);
		por <= 1'b1;
		@(posedge ref_clk);
		por <= 1'b0;
		#1;
		check({ovf, unf}, 16'h0000);
		final_report();
	end
endmodule // tb_core_memory_organization
